// ===== design/dteu_pkg.sv
// Constants and types shared by the diagnostic test and exception unit
package dteu_pkg;

    // Clock and probe reply timeout
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROBE_TIMEOUT_MS = 100;
    localparam int PROBE_TIMEOUT_CYC =
        PROBE_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

    // Supported function codes
    localparam logic [7:0] FC_READ_REGS = 8'h03;
    localparam logic [7:0] FC_WRITE_ONE = 8'h06;
    localparam logic [7:0] FC_WRITE_MANY = 8'h10;
    localparam logic [15:0] MAX_WRITE_QTY = 16'h007B;

    // Exception codes
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
    localparam logic [7:0] EXC_BUSY = 8'h06;
    localparam logic [7:0] EXC_FIELD = 8'h80;
    localparam logic [7:0] EXC_WR_ONLY = 8'h81;
    localparam logic [7:0] EXC_WR_VALUE = 8'h84;
    localparam logic [7:0] EXC_UNK_PROBE = 8'hB0;
    localparam logic [7:0] EXC_BAD_STR = 8'hB1;
    localparam logic [7:0] EXC_LONG_STR = 8'hB2;
    localparam logic [7:0] EXC_PROBE_TMO = 8'hB3;
    localparam logic [7:0] EXC_CRC_RET = 8'hB4;
    localparam logic [7:0] EXC_CRC_SEND = 8'hB5;
    localparam logic [7:0] EXC_PROBE_FLT = 8'hB6;

    // Probe check byte offsets
    localparam logic [7:0] CHK_OFS_CORRUPT = 8'h07;
    localparam logic [7:0] CHK_OFS_FAULT = 8'h38;

    // Holding register map, internal addresses
    localparam logic [16:0] MAP_REGS = 17'h01770;
    localparam logic [15:0] ADDR_SELECT = 16'h0400;
    localparam logic [15:0] ADDR_FAIL = 16'h0402;
    localparam logic [15:0] ADDR_STATUS = 16'h0404;
    localparam logic [15:0] ADDR_CLEAR = 16'h0405;
    localparam logic [15:0] ADDR_LOCAL_END = 16'h0406;
    localparam logic [15:0] SIZE_VECTOR = 16'h0002;
    localparam logic [15:0] SIZE_WORD = 16'h0001;

    // Reset values and field layout
    localparam logic [31:0] SELECT_RESET = 32'h0000_0000;
    localparam logic [31:0] FAIL_RESET = 32'h0000_0000;
    localparam logic [31:0] SELECT_VALID = 32'h0000_05FF;
    localparam int STAT_PWR_EVT = 0;
    localparam int STAT_NO_SYNC = 1;
    localparam int STAT_TESTING = 7;
    localparam int CLEAR_PWR_BIT = 0;

    // Test identifiers, equal to their vector bit positions
    localparam logic [3:0] T_BATTERY = 4'h0;
    localparam logic [3:0] T_PROG_SUM = 4'h1;
    localparam logic [3:0] T_INFO_SUM = 4'h2;
    localparam logic [3:0] T_FERRO = 4'h3;
    localparam logic [3:0] T_LOG_LOW = 4'h4;
    localparam logic [3:0] T_LOG_HIGH = 4'h5;
    localparam logic [3:0] T_TEMP = 4'h6;
    localparam logic [3:0] T_PRESS = 4'h7;
    localparam logic [3:0] T_LOG_FULL = 4'h8;
    localparam logic [3:0] T_BOOT_SUM = 4'hA;
    localparam int TEST_BITS = 11;

    // Pass limits; battery reading is in millivolts
    localparam logic [31:0] BATT_MIN_MV = 32'h0000_0C1C;
    localparam logic [31:0] TEMP_MIN = 32'h0074_0000;
    localparam logic [31:0] TEMP_MAX = 32'h00E5_0000;
    localparam logic [31:0] PRESS_MIN = 32'h0081_0000;
    localparam logic [31:0] PRESS_MAX = 32'h0B00_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b11
    } dteu_state_type;

endpackage : dteu_pkg

// ===== design/dteu_core.sv
// Diagnostic test dispatcher and exception response generator
`timescale 1ns/1ns
`default_nettype none

module dteu_core
    import dteu_pkg::*;
#(
    parameter int PROBE_TIMEOUT = PROBE_TIMEOUT_CYC
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [7:0] req_func_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [15:0] req_qty_in,
    input wire logic [7:0] req_bytes_in,
    input wire logic [31:0] req_wdata_in,
    input wire logic req_struct_bad_in,
    input wire logic req_str_bad_in,
    input wire logic req_str_long_in,
    input wire logic fw_update_in,
    input wire logic probe_known_in,
    output logic resp_valid_out,
    output logic [7:0] resp_exc_out,
    output logic [31:0] resp_data_out,
    output logic probe_fwd_out,
    output logic probe_hold_out,
    input wire logic probe_reply_valid_in,
    input wire logic probe_crc_ok_in,
    input wire logic [7:0] probe_check_byte_in,
    input wire logic [7:0] probe_expect_in,
    input wire logic [31:0] probe_data_in,
    output logic tst_start_out,
    output logic [3:0] tst_id_out,
    input wire logic tst_done_in,
    input wire logic tst_ok_in,
    input wire logic [31:0] tst_value_in,
    input wire logic [31:0] tst_ref_in
);

    if (PROBE_TIMEOUT < 1) begin : g_bad_timeout
        $error("PROBE_TIMEOUT must be at least one cycle");
    end

    typedef struct packed {
        dteu_state_type state;
        logic [31:0] select_r;
        logic [31:0] fail_r;
        logic [TEST_BITS-1:0] pend_r;
        logic running_r;
        logic pwr_evt_r;
        logic probe_wait_r;
        logic [31:0] probe_cnt_r;
        logic resp_valid_r;
        logic [7:0] resp_exc_r;
        logic [31:0] resp_data_r;
        logic probe_fwd_r;
        logic tst_start_r;
        logic [3:0] tst_id_r;
    } dteu_regs_type;
    localparam dteu_regs_type REGS_RESET = '{
        state: ST_IDLE, select_r: SELECT_RESET, fail_r: FAIL_RESET,
        pend_r: '0, running_r: 1'b0, pwr_evt_r: 1'b1, probe_wait_r: 1'b0,
        probe_cnt_r: 32'h0000_0000, resp_valid_r: 1'b0,
        resp_exc_r: EXC_NONE, resp_data_r: 32'h0000_0000,
        probe_fwd_r: 1'b0, tst_start_r: 1'b0, tst_id_r: 4'h0
    };
    dteu_regs_type st_r;
    dteu_regs_type st_nxt;
    logic take_w, is_read_w, is_write_w, is_local_w, probe_end_w;
    logic done_w, test_fail_w, start_w;
    logic [16:0] end_addr_w;
    logic [15:0] field_size_w, status_w;
    logic [7:0] dec_exc_w, probe_exc_w;

    function automatic logic [3:0] lowest_set(
        input logic [TEST_BITS-1:0] vec
    );
        logic [3:0] id;
        id = 4'h0;
        for (int i = TEST_BITS - 1; i >= 0; i--) begin
            if (vec[i]) begin
                id = 4'(i);
            end
        end
        return id;
    endfunction : lowest_set
    // A finishing probe wait owns the response port this cycle
    assign probe_end_w = st_r.probe_wait_r
        && (probe_reply_valid_in || st_r.probe_cnt_r == 32'h0000_0001);
    assign req_ready_out = !probe_end_w;
    assign take_w = req_valid_in && req_ready_out;
    assign done_w = st_r.state == ST_WAIT && tst_done_in;
    assign status_w = {8'h00, st_r.running_r, 5'h00, !probe_known_in,
        st_r.pwr_evt_r};
    assign is_read_w = req_func_in == FC_READ_REGS;
    assign is_write_w = req_func_in == FC_WRITE_ONE
        || req_func_in == FC_WRITE_MANY;
    assign end_addr_w = {1'b0, req_addr_in} + {1'b0, req_qty_in};
    assign is_local_w = req_addr_in >= ADDR_SELECT
        && req_addr_in < ADDR_LOCAL_END;
    always_comb begin
        case (req_addr_in)
            ADDR_SELECT, ADDR_FAIL: field_size_w = SIZE_VECTOR;
            ADDR_STATUS, ADDR_CLEAR: field_size_w = SIZE_WORD;
            default: field_size_w = 16'h0000;
        endcase
    end
    // Request classification, first match wins
    always_comb begin
        dec_exc_w = EXC_NONE;
        if (req_struct_bad_in || req_qty_in == 16'h0000
            || (req_func_in == FC_WRITE_MANY
            && (req_qty_in > MAX_WRITE_QTY
            || req_bytes_in != {req_qty_in[6:0], 1'b0}))) begin
            dec_exc_w = EXC_ILL_VALUE;
        end else if (!is_read_w && !is_write_w) begin
            dec_exc_w = EXC_ILL_FUNC;
        end else if (end_addr_w > MAP_REGS) begin
            dec_exc_w = EXC_ILL_ADDR;
        end else if (is_local_w) begin
            if (field_size_w == 16'h0000
                || req_qty_in != field_size_w) begin
                dec_exc_w = EXC_FIELD;
            end else if (is_read_w && req_addr_in == ADDR_CLEAR) begin
                dec_exc_w = EXC_WR_ONLY;
            end else if (is_write_w && (req_addr_in == ADDR_FAIL
                || req_addr_in == ADDR_STATUS)) begin
                dec_exc_w = EXC_ILL_ADDR;
            end else if (is_write_w && req_addr_in == ADDR_SELECT
                && st_r.running_r) begin
                dec_exc_w = EXC_BUSY;
            end else if (is_write_w && req_addr_in == ADDR_SELECT
                && (req_wdata_in & ~SELECT_VALID) != 32'h0000_0000) begin
                // Reserved selection bits are refused, not masked
                dec_exc_w = EXC_WR_VALUE;
            end
        end else if (st_r.running_r) begin
            dec_exc_w = EXC_ILL_FUNC;
        end else if (!probe_known_in) begin
            dec_exc_w = EXC_UNK_PROBE;
        end else if (is_write_w && req_str_bad_in) begin
            dec_exc_w = EXC_BAD_STR;
        end else if (is_write_w && req_str_long_in) begin
            dec_exc_w = EXC_LONG_STR;
        end
    end
    // Probe reply checks; a missing reply is checked first, then CRC at this end
    always_comb begin
        if (!probe_reply_valid_in) begin
            probe_exc_w = EXC_PROBE_TMO;
        end else if (!probe_crc_ok_in) begin
            probe_exc_w = EXC_CRC_RET;
        end else if (probe_check_byte_in
            == 8'(probe_expect_in + CHK_OFS_CORRUPT)) begin
            probe_exc_w = EXC_CRC_SEND;
        end else if (probe_check_byte_in
            == 8'(probe_expect_in + CHK_OFS_FAULT)) begin
            probe_exc_w = EXC_PROBE_FLT;
        end else begin
            probe_exc_w = EXC_NONE;
        end
    end
    // Verdict for the test whose completion is being reported
    always_comb begin
        case (st_r.tst_id_r)
            T_BATTERY: test_fail_w = tst_value_in < BATT_MIN_MV;
            T_PROG_SUM, T_BOOT_SUM: begin
                test_fail_w = tst_value_in != tst_ref_in;
            end
            T_INFO_SUM: begin
                test_fail_w = tst_value_in[15:0] != tst_ref_in[15:0];
            end
            T_TEMP: begin
                test_fail_w = tst_value_in < TEMP_MIN
                    || tst_value_in > TEMP_MAX;
            end
            T_PRESS: begin
                test_fail_w = tst_value_in < PRESS_MIN
                    || tst_value_in > PRESS_MAX;
            end
            default: test_fail_w = !tst_ok_in;
        endcase
    end

    assign start_w = take_w && !fw_update_in && dec_exc_w == EXC_NONE
        && is_write_w && req_addr_in == ADDR_SELECT
        && req_wdata_in != 32'h0000_0000;
    always_comb begin
        st_nxt = st_r;
        st_nxt.resp_valid_r = 1'b0;
        st_nxt.probe_fwd_r = 1'b0;
        st_nxt.tst_start_r = 1'b0;
        case (st_r.state)
            ST_IDLE: begin
                if (st_r.pend_r != '0) begin
                    st_nxt.state = ST_ISSUE;
                end else begin
                    st_nxt.running_r = 1'b0;
                end
            end
            ST_ISSUE: begin
                // Memory engines restore what they overwrite
                st_nxt.tst_start_r = 1'b1;
                st_nxt.tst_id_r = lowest_set(st_r.pend_r);
                st_nxt.state = ST_WAIT;
            end
            ST_WAIT: begin
                if (tst_done_in) begin
                    st_nxt.pend_r[st_r.tst_id_r] = 1'b0;
                    st_nxt.fail_r[st_r.tst_id_r] = test_fail_w;
                    st_nxt.state = ST_IDLE;
                end
            end
            default: st_nxt.state = ST_IDLE;
        endcase
        if (st_r.probe_wait_r) begin
            if (probe_end_w) begin
                st_nxt.probe_wait_r = 1'b0;
                st_nxt.resp_valid_r = 1'b1;
                st_nxt.resp_exc_r = probe_exc_w;
                st_nxt.resp_data_r = probe_exc_w == EXC_NONE
                    ? probe_data_in : 32'h0000_0000;
            end else begin
                st_nxt.probe_cnt_r = st_r.probe_cnt_r - 32'h0000_0001;
            end
        end
        // Firmware update swallows requests without an answer
        if (take_w && !fw_update_in) begin
            st_nxt.resp_valid_r = 1'b1;
            st_nxt.resp_exc_r = dec_exc_w;
            st_nxt.resp_data_r = 32'h0000_0000;
            if (st_r.probe_wait_r) begin
                st_nxt.resp_exc_r = EXC_BUSY;
            end else if (dec_exc_w == EXC_NONE && !is_local_w) begin
                st_nxt.resp_valid_r = 1'b0;
                st_nxt.probe_wait_r = 1'b1;
                st_nxt.probe_fwd_r = 1'b1;
                st_nxt.probe_cnt_r = 32'(PROBE_TIMEOUT);
            end else if (dec_exc_w == EXC_NONE && is_read_w) begin
                case (req_addr_in)
                    ADDR_SELECT: st_nxt.resp_data_r = st_r.select_r;
                    ADDR_FAIL: st_nxt.resp_data_r = st_r.fail_r;
                    default: st_nxt.resp_data_r = {16'h0000, status_w};
                endcase
            end else if (dec_exc_w == EXC_NONE
                && req_addr_in == ADDR_CLEAR
                && req_wdata_in[CLEAR_PWR_BIT]) begin
                st_nxt.pwr_evt_r = 1'b0;
            end
            if (start_w) begin
                st_nxt.select_r = req_wdata_in;
                st_nxt.pend_r = req_wdata_in[TEST_BITS-1:0];
                st_nxt.fail_r = FAIL_RESET;
                st_nxt.running_r = 1'b1;
                st_nxt.state = ST_IDLE;
            end else if (dec_exc_w == EXC_NONE && is_write_w
                && req_addr_in == ADDR_SELECT) begin
                st_nxt.select_r = req_wdata_in;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= REGS_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign resp_valid_out = st_r.resp_valid_r;
    assign resp_exc_out = st_r.resp_exc_r;
    assign resp_data_out = st_r.resp_data_r;
    assign probe_fwd_out = st_r.probe_fwd_r;
    assign probe_hold_out = st_r.running_r;
    assign tst_start_out = st_r.tst_start_r;
    assign tst_id_out = st_r.tst_id_r;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_battery_low: assert property (done_w && st_r.tst_id_r == T_BATTERY
        && tst_value_in < BATT_MIN_MV |=> st_r.fail_r[0])
        else $error("low battery not flagged");
    a_checksum_bad: assert property (done_w
        && st_r.tst_id_r == T_PROG_SUM && tst_value_in != tst_ref_in
        |=> st_r.fail_r[1])
        else $error("program checksum mismatch not flagged");
    a_temp_range: assert property (done_w && st_r.tst_id_r == T_TEMP
        |=> st_r.fail_r[6] == ($past(tst_value_in) < TEMP_MIN
        || $past(tst_value_in) > TEMP_MAX))
        else $error("temperature verdict wrong");
    a_press_range: assert property (done_w && st_r.tst_id_r == T_PRESS
        |=> st_r.fail_r[7] == ($past(tst_value_in) < PRESS_MIN
        || $past(tst_value_in) > PRESS_MAX))
        else $error("pressure verdict wrong");
    a_full_mem: assert property (done_w && st_r.tst_id_r == T_LOG_FULL
        && !tst_ok_in |=> st_r.fail_r[8])
        else $error("full memory failure not flagged");
    a_bad_func: assert property (take_w && !fw_update_in
        && !st_r.probe_wait_r && !req_struct_bad_in
        && req_qty_in == 16'h0001 && !is_read_w && !is_write_w
        |=> resp_valid_out && resp_exc_out == EXC_ILL_FUNC)
        else $error("unsupported function not answered 0x01");
    a_fw_silent: assert property (take_w && fw_update_in
        && !st_r.probe_wait_r |=> !resp_valid_out)
        else $error("request answered during firmware update");
    a_probe_busy: assert property (take_w && !fw_update_in
        && st_r.running_r && !st_r.probe_wait_r && !is_local_w
        && dec_exc_w != EXC_ILL_VALUE && dec_exc_w != EXC_ILL_ADDR
        && is_read_w |=> resp_exc_out == EXC_ILL_FUNC
        && !probe_fwd_out)
        else $error("probe request during tests not refused");
    a_probe_tmo: assert property (st_r.probe_wait_r
        && st_r.probe_cnt_r == 32'h0000_0001 && !probe_reply_valid_in
        |=> resp_valid_out && resp_exc_out == EXC_PROBE_TMO)
        else $error("probe timeout not answered 0xB3");
    a_start_runs: assert property (start_w |=> st_r.running_r
        && st_r.fail_r == FAIL_RESET ##1 st_r.running_r)
        else $error("start did not raise running");
    a_fail_held: assert property (!start_w && !done_w
        |=> $stable(st_r.fail_r))
        else $error("result vector changed without cause");

    c_test_run: cover property (start_w ##[1:40] tst_start_out);
    c_test_fail: cover property (done_w && test_fail_w);
    c_probe_ok: cover property (probe_fwd_out ##[1:20]
        (resp_valid_out && resp_exc_out == EXC_NONE));
    c_field_bad: cover property (resp_valid_out
        && resp_exc_out == EXC_FIELD);

endmodule : dteu_core

`default_nettype wire

// ===== sim/dteu_far_model.sv
// Far-side model: diagnostic routines and the downstream probe
`timescale 1ns/1ns
`default_nettype none
module dteu_far_model
    import dteu_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic tst_start_in,
    input wire logic [3:0] tst_id_in,
    input wire logic [10:0] fail_mask_in,
    output logic tst_done_out,
    output logic tst_ok_out,
    output logic [31:0] tst_value_out,
    output logic [31:0] tst_ref_out,
    input wire logic probe_fwd_in,
    input wire logic [2:0] probe_mode_in,
    output logic probe_reply_valid_out,
    output logic probe_crc_ok_out,
    output logic [7:0] probe_check_byte_out,
    output logic [7:0] probe_expect_out,
    output logic [31:0] probe_data_out
);
    logic [3:0] id_r;
    logic bad;
    logic [31:0] val;
    logic [31:0] ref_w;
    logic [7:0] ofs;
    int tst_cnt;
    int prb_cnt;
    assign bad = fail_mask_in[id_r];
    assign ref_w = 32'hA5C3_0F96;
    // Battery, temperature and pressure values sit exactly on a pass limit, or one step beyond it
    always_comb begin
        case (id_r)
            T_BATTERY: val = bad ? BATT_MIN_MV - 32'h1 : BATT_MIN_MV;
            T_INFO_SUM: val = bad ? ref_w ^ 32'h1 : ref_w ^ 32'hFFFF_0000;
            T_TEMP: val = bad ? TEMP_MAX + 32'h1 : TEMP_MIN;
            T_PRESS: val = bad ? PRESS_MIN - 32'h1 : PRESS_MAX;
            default: val = bad ? ref_w ^ 32'h8000_0000 : ref_w;
        endcase
        case (probe_mode_in)
            3'h2: ofs = CHK_OFS_CORRUPT;
            3'h3: ofs = CHK_OFS_FAULT;
            default: ofs = 8'h00;
        endcase
    end
    // Lines other than the check byte carry inverted values outside the reply cycle
    assign tst_value_out = tst_done_out ? val : ~val;
    assign tst_ref_out = tst_done_out ? ref_w : ~ref_w;
    assign tst_ok_out = tst_done_out ? !bad : bad;
    assign probe_crc_ok_out = probe_reply_valid_out ^ (probe_mode_in == 3'h1);
    assign probe_expect_out = probe_reply_valid_out ? 8'h20 : 8'hDF;
    assign probe_check_byte_out = probe_reply_valid_out ? 8'h20 + ofs : 8'hC5;
    assign probe_data_out = probe_reply_valid_out ? 32'h1357_9BDF
        : 32'hECA8_6420;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tst_cnt <= 0;
            prb_cnt <= 0;
            id_r <= 4'h0;
            tst_done_out <= 1'b0;
            probe_reply_valid_out <= 1'b0;
        end else begin
            tst_done_out <= (tst_cnt == 1);
            if (tst_start_in) begin
                id_r <= tst_id_in;
                tst_cnt <= 5;
            end else if (tst_cnt != 0) begin
                tst_cnt <= tst_cnt - 1;
            end
            // Mode 4 never answers, to run out the reply timer
            probe_reply_valid_out <= (prb_cnt == 1) && (probe_mode_in != 3'h4);
            if (probe_fwd_in) begin
                prb_cnt <= 3;
            end else if (prb_cnt != 0) begin
                prb_cnt <= prb_cnt - 1;
            end
        end
    end
endmodule : dteu_far_model
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the diagnostic test and exception unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import dteu_pkg::*;
    localparam int TMO = 20;
    logic clk_in, reset_n_in, req_valid_in, req_ready_out, fw_update_in;
    logic req_struct_bad_in, req_str_bad_in, req_str_long_in;
    logic [7:0] req_func_in, req_bytes_in, resp_exc_out, probe_check_byte_in;
    logic [15:0] req_addr_in, req_qty_in;
    logic [31:0] req_wdata_in, resp_data_out, probe_data_in, tst_value_in;
    logic probe_known_in, resp_valid_out, probe_fwd_out, probe_hold_out;
    logic probe_reply_valid_in, probe_crc_ok_in, tst_start_out, tst_done_in;
    logic [7:0] probe_expect_in;
    logic [3:0] tst_id_out;
    logic tst_ok_in;
    logic [31:0] tst_ref_in;
    logic [10:0] fail_mask;
    logic [2:0] probe_mode;
    int err_total, comparisons, cyc;
    dteu_core #(.PROBE_TIMEOUT(TMO)) u_dut (.clk_in, .reset_n_in,
        .req_valid_in, .req_ready_out, .req_func_in, .req_addr_in,
        .req_qty_in, .req_bytes_in, .req_wdata_in, .req_struct_bad_in,
        .req_str_bad_in, .req_str_long_in, .fw_update_in, .probe_known_in,
        .resp_valid_out, .resp_exc_out, .resp_data_out, .probe_fwd_out,
        .probe_hold_out, .probe_reply_valid_in, .probe_crc_ok_in,
        .probe_check_byte_in, .probe_expect_in, .probe_data_in,
        .tst_start_out, .tst_id_out, .tst_done_in, .tst_ok_in,
        .tst_value_in, .tst_ref_in);
    dteu_far_model u_far (.clk_in, .reset_n_in, .tst_start_in(tst_start_out),
        .tst_id_in(tst_id_out), .fail_mask_in(fail_mask),
        .tst_done_out(tst_done_in), .tst_ok_out(tst_ok_in),
        .tst_value_out(tst_value_in), .tst_ref_out(tst_ref_in),
        .probe_fwd_in(probe_fwd_out), .probe_mode_in(probe_mode),
        .probe_reply_valid_out(probe_reply_valid_in),
        .probe_crc_ok_out(probe_crc_ok_in),
        .probe_check_byte_out(probe_check_byte_in),
        .probe_expect_out(probe_expect_in), .probe_data_out(probe_data_in));
    task automatic close_out();
        if (err_total == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Flags are {struct_bad, str_bad, str_long, fw_update}; FF = no answer
    task automatic rq(input string nm, input logic [7:0] f,
        input logic [15:0] a, input logic [15:0] q, input logic [31:0] w,
        input logic [3:0] flg, input logic [7:0] ex, input logic [31:0] d);
        int n;
        logic [7:0] exc;
        logic [31:0] dat;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_func_in <= f;
        req_addr_in <= a;
        req_qty_in <= q;
        req_bytes_in <= 8'(2 * q);
        req_wdata_in <= w;
        {req_struct_bad_in, req_str_bad_in, req_str_long_in, fw_update_in}
            <= flg;
        n = 0;
        @(negedge clk_in);
        while (req_ready_out !== 1'b1 && n < 60) begin
            n++;
            @(negedge clk_in);
        end
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        {req_struct_bad_in, req_str_bad_in, req_str_long_in, fw_update_in}
            <= 4'h0;
        exc = 8'hFF;
        dat = 32'h0;
        for (n = 0; n < TMO + 20 && exc === 8'hFF; n++) begin
            @(negedge clk_in);
            if (resp_valid_out === 1'b1) begin
                exc = resp_exc_out;
                dat = resp_data_out;
            end
        end
        chk({nm, " code"}, {24'h0, ex}, {24'h0, exc});
        if (ex == EXC_NONE) chk({nm, " data"}, d, dat);
    endtask : rq
    task automatic t_reset();
        rq("sel", 8'h03, ADDR_SELECT, 16'h2, 32'h0, 4'h0, 8'h00, 32'h0);
        rq("fail", 8'h03, ADDR_FAIL, 16'h2, 32'h0, 4'h0, 8'h00, 32'h0);
        rq("stat", 8'h03, ADDR_STATUS, 16'h1, 32'h0, 4'h0, 8'h00, 32'h1);
        rq("clr", 8'h06, ADDR_CLEAR, 16'h1, 32'h1, 4'h0, 8'h00, 32'h0);
        rq("stat2", 8'h03, ADDR_STATUS, 16'h1, 32'h0, 4'h0, 8'h00, 32'h0);
    endtask : t_reset
    task automatic t_exc();
        rq("func", 8'h04, 16'h0, 16'h1, 32'h0, 4'h0, 8'h01, 32'h0);
        rq("range", 8'h03, 16'h1770, 16'h1, 32'h0, 4'h0, 8'h02, 32'h0);
        rq("struct", 8'h03, 16'h0, 16'h1, 32'h0, 4'h8, 8'h03, 32'h0);
        rq("qty0", 8'h03, 16'h0, 16'h0, 32'h0, 4'h0, 8'h03, 32'h0);
        rq("qtybig", 8'h10, 16'h0, 16'h7C, 32'h0, 4'h0, 8'h03, 32'h0);
        rq("start", 8'h03, 16'h0401, 16'h2, 32'h0, 4'h0, 8'h80, 32'h0);
        rq("size", 8'h03, ADDR_SELECT, 16'h1, 32'h0, 4'h0, 8'h80, 32'h0);
        rq("wonly", 8'h03, ADDR_CLEAR, 16'h1, 32'h0, 4'h0, 8'h81, 32'h0);
        rq("rsvd", 8'h10, ADDR_SELECT, 16'h2, 32'h200, 4'h0, 8'h84, 32'h0);
        rq("sbad", 8'h06, 16'h10, 16'h1, 32'h0, 4'h4, 8'hB1, 32'h0);
        rq("slong", 8'h06, 16'h10, 16'h1, 32'h0, 4'h2, 8'hB2, 32'h0);
        @(posedge clk_in);
        probe_known_in <= 1'b0;
        rq("unk", 8'h03, 16'h10, 16'h1, 32'h0, 4'h0, 8'hB0, 32'h0);
        probe_known_in <= 1'b1;
    endtask : t_exc
    task automatic t_probe();
        logic [7:0] codes [5] = '{8'h00, 8'hB4, 8'hB5, 8'hB6, 8'hB3};
        for (int m = 0; m < 5; m++) begin
            @(posedge clk_in);
            probe_mode <= 3'(m);
            rq("probe", 8'h03, 16'h10, 16'h2, 32'h0, 4'h0, codes[m], 32'h1357_9BDF);
        end
    endtask : t_probe
    // Probe stays silent, so a second request lands inside the open wait
    task automatic t_overlap();
        int n;
        @(posedge clk_in);
        {req_valid_in, req_func_in, req_addr_in, req_qty_in} <=
            {1'b1, 8'h03, 16'h0010, 16'h0001};
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        rq("ovl", 8'h03, ADDR_STATUS, 16'h1, 32'h0, 4'h0, 8'h06, 32'h0);
        for (n = 0; n < TMO + 20 && req_ready_out !== 1'b0; n++) @(negedge clk_in);
        chk("ready", 32'h0, {31'h0, req_ready_out});
        @(negedge clk_in);
        chk("tmo", {24'h0, EXC_PROBE_TMO},
            {24'h0, resp_exc_out & {8{resp_valid_out}}});
    endtask : t_overlap
    task automatic t_tests(input logic [10:0] mask);
        int n;
        fail_mask = mask;
        rq("go", 8'h10, ADDR_SELECT, 16'h2, SELECT_VALID, 4'h0, 8'h00, 32'h0);
        chk("hold", 32'h1, {31'h0, probe_hold_out});
        rq("busy", 8'h03, ADDR_STATUS, 16'h1, 32'h0, 4'h0, 8'h00, 32'h80);
        rq("pend", 8'h03, 16'h10, 16'h1, 32'h0, 4'h0, 8'h01, 32'h0);
        rq("again", 8'h10, ADDR_SELECT, 16'h2, 32'h1, 4'h0, 8'h06, 32'h0);
        for (n = 0; n < 800 && probe_hold_out !== 1'b0; n++) @(negedge clk_in);
        rq("idle", 8'h03, ADDR_STATUS, 16'h1, 32'h0, 4'h0, 8'h00, 32'h0);
        rq("res", 8'h03, ADDR_FAIL, 16'h2, 32'h0, 4'h0, 8'h00, {21'h0, mask} & SELECT_VALID);
    endtask : t_tests
    task automatic t_zero_fw();
        rq("zero", 8'h10, ADDR_SELECT, 16'h2, 32'h0, 4'h0, 8'h00, 32'h0);
        chk("nohold", 32'h0, {31'h0, probe_hold_out});
        rq("kept", 8'h03, ADDR_FAIL, 16'h2, 32'h0, 4'h0, 8'h00, 32'h56);
        rq("fw", 8'h03, ADDR_STATUS, 16'h1, 32'h0, 4'h1, 8'hFF, 32'h0);
    endtask : t_zero_fw
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        {reset_n_in, req_valid_in, req_struct_bad_in, fw_update_in} = 4'h0;
        {req_str_bad_in, req_str_long_in, req_func_in} = 10'h0;
        {req_addr_in, req_qty_in, req_bytes_in, req_wdata_in} = 72'h0;
        probe_known_in = 1'b1;
        probe_mode = 3'h0;
        fail_mask = 11'h0;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_exc();
        t_probe();
        t_overlap();
        t_tests(11'h5A9);
        t_tests(11'h056);
        t_zero_fw();
        close_out();
    end
endmodule : testbench
`default_nettype wire
